// ### dv/pcs_ctrl_store_tb_top.sv
// self-checking bench for the control store
// drives the register port and timeslot index itself
`timescale 1ns/1ps
`default_nettype none
module pcs_ctrl_store_tb_top import pcs_pkg::*;;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h0, tx;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, en;
    logic [5:0] ts_index = 6'h0, a;
    logic [7:0] mem [64];
    int err_count = 0, checks = 0, seed = 87940, i, k;
    pcs_ctrl_store u_pcs_ctrl_store (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ts_index(ts_index),
        .tx_per_channel_ctrl(tx), .ctrl_stream_enable(en));
    // clock and watchdog
    initial forever #2.5 pclk = ~pclk;
    initial begin
        #100000;
        err_count++;
        give_verdict();
    end
    function automatic logic [31:0] exp_tx(logic e, logic [5:0] t);
        return e ? {24'h0, mem[t]} : 32'h0;
    endfunction : exp_tx
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task idle;
        k = 0;
        do begin
            apb(1'b0, PCS_STAT_OFF, 32'h0);
            k++;
        end while (q[0] !== 1'b0 && k < 8);
        chk(q & 32'h1, 32'h0);
    endtask : idle
    task indirect_select(input logic rnw, input logic [5:0] ad);
        idle();
        apb(1'b1, PCS_ADDR_OFF, {24'h0, rnw, 1'b0, ad});
        apb(1'b0, PCS_STAT_OFF, 32'h0);
        chk(q & 32'h1, 32'h1);
        idle();
    endtask : indirect_select
    task give_verdict;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    // reset, fill, read back, enable, unmapped read
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, PCS_CFG_OFF, 32'h0);
        chk(q, 32'h0);
        apb(1'b1, PCS_CFG_OFF, 32'h2);
        for (i = 0; i < 64; i++) begin
            mem[i] = 8'($random(seed));
            apb(1'b1, PCS_DATA_OFF, {24'h0, mem[i]});
            indirect_select(1'b0, i[5:0]);
            ts_index <= 6'($random(seed));
        end
        chk({24'h0, tx}, exp_tx(1'b0, ts_index));
        $display("test fill done");
        for (i = 0; i < 10; i++) begin
            a = (i < 2) ? 6'(i * 63) : 6'($random(seed));
            indirect_select(1'b1, a);
            apb(1'b0, PCS_DATA_OFF, 32'h0);
            chk(q, {24'h0, mem[a]});
        end
        $display("test read done");
        apb(1'b1, PCS_CFG_OFF, 32'h3);
        for (i = 0; i < 8; i++) begin
            ts_index <= 6'($random(seed));
            repeat (3) @(posedge pclk);
            chk({24'h0, tx}, exp_tx(1'b1, ts_index));
        end
        apb(1'b0, 8'h10, 32'h0);
        chk(q, 32'h0);
        $display("test stream done");
        give_verdict();
    end
endmodule : pcs_ctrl_store_tb_top
`default_nettype wire

// ### dv/pcs_monitor.sv
// checker for the control store register port
// bound to pcs_ctrl_store, one clock domain on pclk
`timescale 1ns/1ps
`default_nettype none
module pcs_monitor
    import pcs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [PCS_AW-1:0] ts_index,
    input wire logic [PCS_DW-1:0] tx_per_channel_ctrl,
    input wire logic ctrl_stream_enable
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // access decode
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire st_rd = rd && paddr == PCS_STAT_OFF;
    logic ind_ff;
    logic [1:0] cnt_ff;
    wire go = wr && paddr == PCS_ADDR_OFF && ind_ff && cnt_ff == 2'h0;
    // shadow of the mode bit and of the busy window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ind_ff <= 1'b0;
            cnt_ff <= 2'h0;
        end else begin
            if (wr && paddr == PCS_CFG_OFF) ind_ff <= pwdata[1];
            if (go) cnt_ff <= 2'h3;
            else if (cnt_ff != 2'h0) cnt_ff <= cnt_ff - 2'h1;
        end
    end
    sequence s_go;
        go;
    endsequence
    a_mode_reset: assert property (rd && paddr == PCS_CFG_OFF |->
        prdata[1] == ind_ff) else $error("mode bit wrong");
    a_en_write: assert property (wr && paddr == PCS_CFG_OFF |=>
        ctrl_stream_enable == $past(pwdata[0])) else $error("enable wrong");
    a_out_off: assert property (!ctrl_stream_enable &&
        !$past(ctrl_stream_enable) |-> tx_per_channel_ctrl == 8'h00)
        else $error("stream not off");
    a_busy_rise: assert property (s_go ##[2:4] st_rd |-> prdata[0])
        else $error("busy not raised");
    a_busy_hold: assert property (st_rd && $past(cnt_ff) != 2'h0 |->
        prdata[0]) else $error("busy dropped early");
    a_busy_done: assert property (st_rd && $past(cnt_ff) == 2'h0 |->
        !prdata[0]) else $error("busy stuck");
    a_unmap_zero: assert property (rd && paddr > PCS_DATA_OFF |->
        prdata == 32'h0) else $error("unmapped read not zero");
    a_zero_wait: assert property (acc |-> pready && !pslverr)
        else $error("wait or error seen");
endmodule : pcs_monitor
bind pcs_ctrl_store pcs_monitor u_pcs_monitor (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ts_index(ts_index), .tx_per_channel_ctrl(tx_per_channel_ctrl),
    .ctrl_stream_enable(ctrl_stream_enable));
`default_nettype wire

// ### hdl/pcs_ctrl_store.sv
// transmit per-channel control store with indirect apb access
// assumes apb master on pclk; timeslot index from the frame logic
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pcs_ctrl_store
    import pcs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [PCS_AW-1:0] ts_index,
    output logic [PCS_DW-1:0] tx_per_channel_ctrl,
    output logic ctrl_stream_enable
);
    // control store, one byte per timeslot
    logic [PCS_DW-1:0] mem_ff [PCS_DEPTH];
    // per-location write strobes from the sequencer
    logic [PCS_DEPTH-1:0] loc_we;

    // configuration: bit0 stream enable, bit1 indirect select
    logic [1:0] cfg_ff;
    logic [1:0] nxt_cfg;

    // indirect data buffer shared by reads and writes
    logic [PCS_DW-1:0] buf_ff;
    logic [PCS_DW-1:0] nxt_buf;

    // latched timeslot address and direction of the request
    logic [PCS_AW-1:0] addr_ff;
    logic [PCS_AW-1:0] nxt_addr;
    logic rnw_ff;
    logic nxt_rnw;

    // busy sequencer state, flag and wait counter
    pcs_state_t st_ff;
    pcs_state_t nxt_st;
    logic busy_ff;
    logic nxt_busy;
    logic [1:0] cnt_ff;
    logic [1:0] nxt_cnt;

    // registered bus answer
    logic [31:0] rd_ff;
    logic [31:0] nxt_rd;
    logic ready_ff;
    logic nxt_ready;
    logic err_ff;

    // registered stream output
    logic [PCS_DW-1:0] out_ff;
    logic [PCS_DW-1:0] nxt_out;

    // apb phase decode
    wire logic setup = psel & ~penable;
    wire logic acc = psel & penable;
    wire logic wr = acc & pwrite;

    // register hits on the byte address
    wire logic hit_cfg = paddr == PCS_CFG_OFF;
    wire logic hit_stat = paddr == PCS_STAT_OFF;
    wire logic hit_addr = paddr == PCS_ADDR_OFF;
    wire logic hit_data = paddr == PCS_DATA_OFF;

    // write strobes per register
    wire logic wr_cfg = wr & hit_cfg;
    wire logic wr_addr = wr & hit_addr;
    wire logic wr_data = wr & hit_data;

    // field views of the write data
    wire logic [1:0] wd_cfg = pwdata[1:0];
    wire logic [PCS_AW-1:0] wd_loc = pwdata[PCS_AW-1:0];
    wire logic wd_rnw = pwdata[PCS_ADDR_RNW_BIT];
    wire logic [PCS_DW-1:0] wd_byte = pwdata[PCS_DW-1:0];

    // mode bits as named wires
    wire logic ind_mode = cfg_ff[PCS_CFG_IND_BIT];
    wire logic en_mode = cfg_ff[PCS_CFG_EN_BIT];

    // request start, indirect mode and idle only
    wire logic start = wr_addr & ind_mode & ~busy_ff;

    // completion cycle of the request, split by direction
    wire logic done = st_ff == PCS_DO;
    wire logic done_rd = done & rnw_ff;
    wire logic done_wr = done & ~rnw_ff;

    // software write to the buffer, refused while busy
    wire logic buf_sw = wr_data & ~busy_ff;

    // read selection, unmapped addresses read zero
    wire logic [31:0] rd_mux =
        hit_cfg ? {30'h0, cfg_ff} :
        hit_stat ? {31'h0, busy_ff} :
        hit_addr ? {24'h0, rnw_ff, 1'b0, addr_ff} :
        hit_data ? {24'h0, buf_ff} : 32'h0;

    // configuration changes only on a software write
    assign nxt_cfg = wr_cfg ? wd_cfg : cfg_ff;

    // address/control captured when a request starts
    assign nxt_addr = start ? wd_loc : addr_ff;
    assign nxt_rnw = start ? wd_rnw : rnw_ff;

    // a finished read wins over a software load
    assign nxt_buf = done_rd ? mem_ff[addr_ff] :
        buf_sw ? wd_byte : buf_ff;

    // answer taken at the setup edge, so access needs no wait
    assign nxt_ready = setup;
    assign nxt_rd = setup ? rd_mux : rd_ff;

    // stream value, forced to reset value while disabled
    assign nxt_out = en_mode ? mem_ff[ts_index] : PCS_DATA_RST;

    // busy sequencer: two wait cycles, one done cycle
    always_comb begin
        nxt_st = st_ff;
        nxt_busy = busy_ff;
        nxt_cnt = cnt_ff;
        case (st_ff)
            PCS_IDLE: begin
                if (start) begin
                    nxt_st = PCS_WAIT;
                    nxt_busy = 1'b1;
                    nxt_cnt = PCS_ACC_CYC;
                end
            end
            PCS_WAIT: begin
                nxt_cnt = cnt_ff - 2'h1;
                if (cnt_ff == 2'h1) begin
                    nxt_st = PCS_DO;
                end
            end
            PCS_DO: begin
                nxt_st = PCS_IDLE;
                nxt_busy = 1'b0;
            end
            default: begin
                nxt_st = PCS_IDLE;
                nxt_busy = 1'b0;
                nxt_cnt = '0;
            end
        endcase
    end

    // config reset: direct mode, streams off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff <= PCS_CFG_RST;
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    // latched timeslot address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_ff <= '0;
        end else begin
            addr_ff <= nxt_addr;
        end
    end

    // latched direction of the request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rnw_ff <= 1'b0;
        end else begin
            rnw_ff <= nxt_rnw;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_ff <= PCS_DATA_RST;
        end else begin
            buf_ff <= nxt_buf;
        end
    end

    // sequencer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= PCS_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= nxt_busy;
        end
    end

    // wait counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // store write into the addressed location
    genvar gi;
    generate
        for (gi = 0; gi < PCS_DEPTH; gi++) begin : g_loc
            // strobe for this location only
            assign loc_we[gi] = done_wr & (addr_ff == PCS_AW'(gi));
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    mem_ff[gi] <= PCS_DATA_RST;
                end else if (loc_we[gi]) begin
                    mem_ff[gi] <= buf_ff;
                end
            end
        end
    endgenerate

    // read data held from setup through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ff <= 32'h0;
        end else begin
            rd_ff <= nxt_rd;
        end
    end

    // ready high exactly in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_ff <= 1'b0;
        end else begin
            ready_ff <= nxt_ready;
        end
    end

    // no access is ever refused with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_ff <= 1'b0;
        end else begin
            err_ff <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ff <= PCS_DATA_RST;
        end else begin
            out_ff <= nxt_out;
        end
    end

    // outputs straight from flip-flops
    assign pready = ready_ff;
    assign pslverr = err_ff;
    assign prdata = rd_ff;
    assign tx_per_channel_ctrl = out_ff;
    assign ctrl_stream_enable = cfg_ff[PCS_CFG_EN_BIT];
endmodule : pcs_ctrl_store
`default_nettype wire

// ### include/pcs_pkg.sv
// package for the transmit per-channel control store
// assumes an apb slave top module, one clock domain
// Behaviour
// - with enable set, outputs are driven from stored data.
// - reset selects direct access, indirect_select cleared.
// - busy reads 1 while an indirect request is in progress.
// - busy reads 0 once the request is complete.
// - address/control write with read_not_write 0 stores buffer data.
// - busy rises right after address/control write, falls when done.
// - address/control write with read_not_write 1 reads into buffer.
package pcs_pkg;
    localparam int PCS_DEPTH = 64;
    localparam int PCS_AW = 6;
    localparam int PCS_DW = 8;
    // byte offsets of the registers
    localparam logic [7:0] PCS_CFG_OFF = 8'h00;
    localparam logic [7:0] PCS_STAT_OFF = 8'h04;
    localparam logic [7:0] PCS_ADDR_OFF = 8'h08;
    localparam logic [7:0] PCS_DATA_OFF = 8'h0c;
    // configuration fields
    localparam int PCS_CFG_EN_BIT = 0;
    localparam int PCS_CFG_IND_BIT = 1;
    localparam logic [1:0] PCS_CFG_RST = 2'h0;
    // status and address/control fields
    localparam int PCS_STAT_BUSY_BIT = 0;
    localparam int PCS_ADDR_RNW_BIT = 7;
    localparam logic [PCS_DW-1:0] PCS_DATA_RST = 8'h00;
    // wait cycles of one indirect request; busy stays high one cycle longer
    localparam logic [1:0] PCS_ACC_CYC = 2'h2;
    typedef enum logic [1:0] {PCS_IDLE, PCS_WAIT, PCS_DO} pcs_state_t;
endpackage : pcs_pkg
